/* File: irx_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// decoder checker
// ----------------------------------------
module irx_chk
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // fetch and context inputs
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic extension_config_bit,
   input wire logic irq_level_high,
   input wire logic [irx_pkg::IRX_PC_W-1:0] stack_top,
   input wire irx_pkg::irx_ctx_t shadow_ctx,
   // design outputs
   input wire logic global_high_irq_enable,
   input wire logic global_low_irq_enable,
   input wire logic stack_pop,
   input wire logic stack_push,
   input wire logic pc_load,
   input wire logic [irx_pkg::IRX_PC_W-1:0] pc_value,
   input wire irx_pkg::irx_ctx_t work_ctx,
   input wire logic [irx_pkg::IRX_PTR_W-1:0] ptr0,
   input wire logic [irx_pkg::IRX_PTR_W-1:0] file_pointer_two,
   input wire irx_pkg::irx_mem_t mem_wr
);
   import irx_pkg::*;
   logic skip_reg, mov_reg, take, ret, ext, two, sel3;
   assign ext = extension_config_bit;
   assign take = instr_valid && !skip_reg && !mov_reg;
   assign ret = (instr_word & IRX_OP_RETIRQ_MASK) == IRX_OP_RETIRQ;
   assign sel3 = instr_word[7:6] == IRX_SEL_RETURN;
   // word after a two-cycle op is a no-op slot, never decoded
   assign two = ret || instr_word[15:8] == IRX_OP_RETLIT || ext
      && (instr_word == IRX_OP_CALLACC || instr_word[15:9] == 7'h74 && sel3);
   always_ff @(posedge clock or negedge resetn)
      if (!resetn) skip_reg <= 1'b0;
      else skip_reg <= take && two;
   always_ff @(posedge clock or negedge resetn)
      if (!resetn) mov_reg <= 1'b0;
      else if (mov_reg) mov_reg <= !instr_valid;
      else mov_reg <= take && ext && instr_word[15:8] == IRX_OP_MOVIDX;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ret_pop_a: assert property (take && ret
      |=> stack_pop && pc_load && pc_value == $past(stack_top))
      else $error("return pop wrong");
   ret_enable_a: assert property (take && ret
      |=> ($past(irq_level_high) ? global_high_irq_enable
      : global_low_irq_enable)) else $error("irq enable not set");
   fast_restore_a: assert property (take && ret |=>
      work_ctx == ($past(instr_word[0]) ? $past(shadow_ctx) : $past(work_ctx)))
      else $error("shadow restore wrong");
   ret_gap_a: assert property (take && ret
      |=> ##1 !pc_load && !stack_pop) else $error("no-op cycle acted");
   ret_lit_a: assert property (take
      && instr_word[15:8] == IRX_OP_RETLIT
      |=> stack_pop && work_ctx.acc == $past(instr_word[7:0]))
      else $error("literal return wrong");
   ext_off_a: assert property (take && !ext
      && instr_word[15:12] == 4'he
      |=> $stable(ptr0) && $stable(file_pointer_two) && !mem_wr.we)
      else $error("extension ran while off");
   ptr_add_a: assert property (take && ext
      && instr_word[15:6] == 10'h3a0
      |=> ptr0 == $past(ptr0) + {6'h00, $past(instr_word[5:0])})
      else $error("pointer add wrong");
   add_ret_a: assert property (take && ext
      && instr_word[15:6] == 10'h3a3
      |=> pc_load && stack_pop && file_pointer_two == $past(file_pointer_two)
      + {6'h00, $past(instr_word[5:0])}) else $error("add and return wrong");
   sub_ret_a: assert property (take && ext
      && instr_word[15:6] == 10'h3a7
      |=> pc_load && stack_pop && file_pointer_two == $past(file_pointer_two)
      - {6'h00, $past(instr_word[5:0])}) else $error("sub and return wrong");
   call_acc_a: assert property (take && ext
      && instr_word == IRX_OP_CALLACC
      |=> stack_push && pc_load && pc_value[7:0] == $past(work_ctx.acc))
      else $error("accumulator call wrong");
   push_lit_a: assert property (take && ext
      && instr_word[15:8] == IRX_OP_PUSHLIT
      |=> mem_wr.we && mem_wr.addr == $past(file_pointer_two)
      && file_pointer_two == $past(file_pointer_two) - 12'h001)
      else $error("literal push wrong");
   move_write_a: assert property (mov_reg && instr_valid
      && instr_word[15:12] == IRX_OP_SECOND |=> mem_wr.we)
      else $error("move write missing");
   cover property (take && ret);
   cover property (take && ext && instr_word[15:8] == IRX_OP_PUSHLIT);
   cover property (mov_reg && instr_valid);
endmodule // irx_chk

/* File: irx_decoder.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - return-from-irq pops stack top into pc; upper pc latches untouched.
// - return-from-irq sets high or low global irq enable per level.
// - fast bit 1 restores accumulator, status, bank; 0 leaves them.
// - extension group decodes only while the extension config bit is set.
// - extension adds eight instructions for indirect, indexed addressing.
// - pointer add/sub: 2-bit select, 6-bit literal, one cycle, no flags.
// - select 11 on add acts on pointer two, then returns; two cycles.
// - select 11 on sub acts on pointer two, then returns; two cycles.
// - call via accumulator: two cycles, low target byte from accumulator, upper bytes from pc latches, no flags.
// - indexed-to-absolute move: 7-bit offset, 12-bit address, two cycles.
// - indexed-to-indexed move: 7-bit offsets off pointer two, two cycles.
// - push literal stores at pointer two, decrements it, one cycle.
module irx_decoder
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // fetch stage
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   output logic instr_ready,
   // configuration and irq state
   input wire logic extension_config_bit,
   input wire logic irq_level_high,
   output logic global_high_irq_enable,
   output logic global_low_irq_enable,
   input wire logic irq_disable_high,
   input wire logic irq_disable_low,
   // stack
   input wire logic [irx_pkg::IRX_PC_W-1:0] stack_top,
   output logic stack_pop,
   output logic stack_push,
   input wire logic [irx_pkg::IRX_PC_W-1:0] pc_return,
   input wire logic [7:0] pc_high_latch,
   input wire logic [7:0] pc_upper_latch,
   // program counter
   output logic pc_load,
   output logic [irx_pkg::IRX_PC_W-1:0] pc_value,
   // working registers and shadows
   input wire irx_pkg::irx_ctx_t shadow_ctx,
   output irx_pkg::irx_ctx_t work_ctx,
   // file pointers
   output logic [irx_pkg::IRX_PTR_W-1:0] ptr0,
   output logic [irx_pkg::IRX_PTR_W-1:0] ptr1,
   output logic [irx_pkg::IRX_PTR_W-1:0] file_pointer_two,
   // data memory
   output logic mem_re,
   output logic [irx_pkg::IRX_PTR_W-1:0] mem_raddr,
   input wire logic [7:0] mem_rdata,
   output irx_pkg::irx_mem_t mem_wr
);
   import irx_pkg::*;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic is_ext(input logic [15:0] w, input logic en);
      is_ext = en && (w[15:8] == IRX_OP_PTRADD || w[15:8] == IRX_OP_PTRSUB
         || w[15:8] == IRX_OP_PUSHLIT || w[15:8] == IRX_OP_MOVIDX
         || w == IRX_OP_CALLACC);
   endfunction

   function automatic logic [IRX_PTR_W-1:0] idx(input logic [IRX_PTR_W-1:0] p,
      input logic [6:0] off);
      idx = p + {5'h00, off};
   endfunction

   irx_state_t state_reg;
   logic [IRX_PTR_W-1:0] ptr_reg [3];
   logic [6:0] src_off_reg;
   logic [7:0] lit_reg;
   logic move_abs_reg;
   logic rd_pend_reg;
   logic go;
   logic op_ret_irq, op_ret_lit, op_add, op_sub, op_push, op_call, op_mov;
   logic [1:0] sel;
   logic [IRX_PTR_W-1:0] lit6;

   assign instr_ready = 1'b1;
   assign go = instr_valid && state_reg == IRX_ST_DECODE;
   assign sel = instr_word[IRX_SEL_HI:IRX_SEL_LO];
   assign lit6 = {6'h00, instr_word[5:0]};
   assign op_ret_irq = go
      && (instr_word & IRX_OP_RETIRQ_MASK) == IRX_OP_RETIRQ;
   assign op_ret_lit = go && instr_word[15:8] == IRX_OP_RETLIT;
   assign op_add = go && is_ext(instr_word, extension_config_bit)
      && instr_word[15:8] == IRX_OP_PTRADD;
   assign op_sub = go && is_ext(instr_word, extension_config_bit)
      && instr_word[15:8] == IRX_OP_PTRSUB;
   assign op_push = go && is_ext(instr_word, extension_config_bit)
      && instr_word[15:8] == IRX_OP_PUSHLIT;
   assign op_call = go && is_ext(instr_word, extension_config_bit)
      && instr_word == IRX_OP_CALLACC;
   assign op_mov = go && is_ext(instr_word, extension_config_bit)
      && instr_word[15:8] == IRX_OP_MOVIDX;

   assign ptr0 = ptr_reg[0];
   assign ptr1 = ptr_reg[1];
   assign file_pointer_two = ptr_reg[IRX_SEL_PTR2];

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         state_reg <= IRX_ST_DECODE;
      else
         case (state_reg)
            IRX_ST_DECODE:
               if (op_mov)
                  state_reg <= IRX_ST_MOV2;
               else if (op_ret_irq || op_ret_lit || op_call
                  || ((op_add || op_sub) && sel == IRX_SEL_RETURN))
                  state_reg <= IRX_ST_NOP;
            IRX_ST_NOP:
               state_reg <= IRX_ST_DECODE;
            IRX_ST_MOV2:
               if (instr_valid)
                  state_reg <= IRX_ST_DECODE;
            default:
               state_reg <= IRX_ST_DECODE;
         endcase
   end

   // ----------------------------------------
   // program counter and stack
   // ----------------------------------------
   // pc latches are only observed, never written here
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pc_load <= 1'b0;
         pc_value <= IRX_PC_RST;
         stack_pop <= 1'b0;
         stack_push <= 1'b0;
      end
      else
      begin
         pc_load <= 1'b0;
         stack_pop <= 1'b0;
         stack_push <= 1'b0;
         if (op_ret_irq || op_ret_lit
            || ((op_add || op_sub) && sel == IRX_SEL_RETURN))
         begin
            pc_load <= 1'b1;
            pc_value <= stack_top;
            stack_pop <= 1'b1;
         end
         else if (op_call)
         begin
            pc_load <= 1'b1;
            stack_push <= 1'b1;
            pc_value <= {pc_upper_latch[4:0], pc_high_latch,
               work_ctx.acc};
         end
      end
   end

   // ----------------------------------------
   // irq enables
   // ----------------------------------------
   // a set by return wins over a clear arriving the same cycle
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         global_high_irq_enable <= 1'b0;
         global_low_irq_enable <= 1'b0;
      end
      else
      begin
         if (op_ret_irq && irq_level_high)
            global_high_irq_enable <= 1'b1;
         else if (irq_disable_high)
            global_high_irq_enable <= 1'b0;
         if (op_ret_irq && !irq_level_high)
            global_low_irq_enable <= 1'b1;
         else if (irq_disable_low)
            global_low_irq_enable <= 1'b0;
      end
   end

   // ----------------------------------------
   // working registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         work_ctx <= '{IRX_BYTE_RST, IRX_BYTE_RST, IRX_BYTE_RST};
      else if (op_ret_irq && instr_word[IRX_FAST_BIT])
         work_ctx <= shadow_ctx;
      else if (op_ret_lit)
         work_ctx.acc <= instr_word[7:0];
   end

   // ----------------------------------------
   // file pointers
   // ----------------------------------------
   // no status flags touched by any pointer arithmetic
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_ptr
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               ptr_reg[i] <= IRX_PTR_RST;
            else if (op_add && (sel == 2'(i)
               || (i == 2 && sel == IRX_SEL_RETURN)))
               ptr_reg[i] <= ptr_reg[i] + lit6;
            else if (op_sub && (sel == 2'(i)
               || (i == 2 && sel == IRX_SEL_RETURN)))
               ptr_reg[i] <= ptr_reg[i] - lit6;
            else if (i == 2 && op_push)
               ptr_reg[i] <= ptr_reg[i] - 12'h001;
         end
      end
   endgenerate

   // ----------------------------------------
   // moves and push
   // ----------------------------------------
   // source read issued in word one; memory returns data next cycle
   assign mem_re = op_mov;
   assign mem_raddr = idx(file_pointer_two, instr_word[6:0]);

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         src_off_reg <= 7'h00;
         lit_reg <= IRX_BYTE_RST;
         move_abs_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         mem_wr <= '{1'b0, IRX_PTR_RST, IRX_BYTE_RST};
      end
      else
      begin
         mem_wr.we <= 1'b0;
         rd_pend_reg <= op_mov;
         // read data stands one cycle only; keep it for a late second word
         if (rd_pend_reg)
            lit_reg <= mem_rdata;
         if (op_mov)
         begin
            src_off_reg <= instr_word[6:0];
            move_abs_reg <= !instr_word[IRX_MOV_KIND_BIT];
         end
         if (op_push)
            mem_wr <= '{1'b1, file_pointer_two, instr_word[7:0]};
         if (state_reg == IRX_ST_MOV2 && instr_valid
            && instr_word[15:12] == IRX_OP_SECOND)
         begin
            mem_wr.we <= 1'b1;
            mem_wr.data <= rd_pend_reg ? mem_rdata : lit_reg;
            mem_wr.addr <= move_abs_reg ? instr_word[11:0]
               : idx(file_pointer_two, instr_word[6:0]);
         end
      end
   end
endmodule // irx_decoder

/* File: irx_pkg.sv */
package irx_pkg;
   // ----------------------------------------
   // opcode fields
   // ----------------------------------------
   localparam logic [15:0] IRX_OP_RETIRQ_MASK = 16'hfffe;
   localparam logic [15:0] IRX_OP_RETIRQ = 16'h0010;
   localparam logic [15:0] IRX_OP_CALLACC = 16'h0014;
   localparam logic [7:0] IRX_OP_RETLIT = 8'h0c;
   localparam logic [7:0] IRX_OP_PTRADD = 8'he8;
   localparam logic [7:0] IRX_OP_PTRSUB = 8'he9;
   localparam logic [7:0] IRX_OP_PUSHLIT = 8'hea;
   localparam logic [7:0] IRX_OP_MOVIDX = 8'heb;
   localparam logic [3:0] IRX_OP_SECOND = 4'hf;
   localparam int IRX_FAST_BIT = 0;
   localparam int IRX_SEL_HI = 7;
   localparam int IRX_SEL_LO = 6;
   localparam int IRX_MOV_KIND_BIT = 7;
   localparam logic [1:0] IRX_SEL_PTR2 = 2'h2;
   localparam logic [1:0] IRX_SEL_RETURN = 2'h3;
   localparam int IRX_PC_W = 21;
   localparam int IRX_PTR_W = 12;
   localparam logic [IRX_PC_W-1:0] IRX_PC_RST = 21'h000000;
   localparam logic [IRX_PTR_W-1:0] IRX_PTR_RST = 12'h000;
   localparam logic [7:0] IRX_BYTE_RST = 8'h00;

   typedef enum {IRX_ST_DECODE, IRX_ST_NOP, IRX_ST_MOV2} irx_state_t;

   // working registers with their shadows
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] status;
      logic [7:0] bank;
   } irx_ctx_t;

   // data memory write request
   typedef struct packed {
      logic we;
      logic [IRX_PTR_W-1:0] addr;
      logic [7:0] data;
   } irx_mem_t;
endpackage

/* File: irx_prog_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// stack and data memory model
// ----------------------------------------
module irx_prog_model
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // stack side
   input wire logic stack_pop,
   input wire logic stack_push,
   input wire logic [irx_pkg::IRX_PC_W-1:0] pc_value,
   output logic [irx_pkg::IRX_PC_W-1:0] stack_top,
   output logic [irx_pkg::IRX_PC_W-1:0] pc_return,
   output irx_pkg::irx_ctx_t shadow_ctx,
   // data memory side
   input wire logic mem_re,
   input wire logic [irx_pkg::IRX_PTR_W-1:0] mem_raddr,
   output logic [7:0] mem_rdata,
   input wire irx_pkg::irx_mem_t mem_wr
);
   import irx_pkg::*;
   logic [7:0] mem [0:4095];
   logic [IRX_PC_W-1:0] stk [0:3];
   logic [1:0] sp;
   assign stack_top = stk[sp];
   assign pc_return = pc_value + 21'h000001;
   assign shadow_ctx = {8'ha5, 8'h1e, 8'h07};
   initial
   begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h3c;
      for (int i = 0; i < 4; i++) stk[i] = 21'h000100 * 21'(i + 1);
      mem_rdata = 8'h00;
   end
   // four-deep ring: deep call chains wrap silently
   always @(posedge clock or negedge resetn)
      if (!resetn) sp <= 2'h0;
      else if (stack_push)
      begin
         sp <= sp + 2'h1;
         stk[sp + 2'h1] <= pc_return;
      end
      else if (stack_pop) sp <= sp - 2'h1;
   // unread data toggles so a missed read never looks right
   always @(posedge clock)
   begin
      if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
      mem_rdata <= mem_re ? mem[mem_raddr] : ~mem_rdata;
   end
endmodule // irx_prog_model

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
   $display("Error at %0t: got %h want %h", $time, a, b); end end
// ----------------------------------------
// testbench top
// ----------------------------------------
module tb;
   import irx_pkg::*;
   logic clock = 0, resetn = 0, instr_valid = 0, instr_ready;
   logic [15:0] instr_word = 16'h0000;
   logic extension_config_bit = 0, irq_level_high = 1;
   logic irq_disable_high = 0, irq_disable_low = 0;
   logic global_high_irq_enable, global_low_irq_enable;
   logic stack_pop, stack_push, pc_load, mem_re;
   logic [IRX_PC_W-1:0] stack_top, pc_return, pc_value, st;
   logic [7:0] pc_high_latch = 8'h12, pc_upper_latch = 8'h03, mem_rdata;
   logic [IRX_PTR_W-1:0] ptr0, ptr1, file_pointer_two, mem_raddr;
   irx_ctx_t shadow_ctx, work_ctx;
   irx_mem_t mem_wr;
   int n_tests = 0, miscompares = 0;
   irx_decoder dut (.*);
   irx_prog_model far (.*);
   initial forever #12.5 clock = ~clock;
   task op(input logic [15:0] w);
      @(negedge clock);
      instr_valid = 1'b1;
      instr_word = w;
      @(negedge clock);
      instr_valid = 1'b0;
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(negedge clock);
      resetn = 1'b1;
      op(16'he805); `CHK(ptr0, 12'h000)
      extension_config_bit = 1'b1;
      op(16'he805); `CHK(ptr0, 12'h005)
      op(16'he942); `CHK(ptr1, 12'hffe)
      op(16'he88a); `CHK(file_pointer_two, 12'h00a)
      op(16'hea5a); `CHK(mem_wr, {1'b1, 12'h00a, 8'h5a})
      `CHK(file_pointer_two, 12'h009)
      $display("pointer test done");
      st = stack_top; op(16'he8c3); `CHK(pc_value, st)
      `CHK(file_pointer_two, 12'h00c)
      @(negedge clock); // the pop lands one edge after the check
      st = stack_top; op(16'he9c4); `CHK(pc_value, st)
      `CHK(file_pointer_two, 12'h008)
      @(negedge clock);
      st = stack_top; op(16'h0c77); `CHK(work_ctx.acc, 8'h77)
      `CHK(pc_value, st)
      irq_level_high = 1'b0;
      @(negedge clock);
      st = stack_top; op(16'h0010); `CHK(pc_value, st)
      `CHK(global_low_irq_enable, 1'b1)
      `CHK(work_ctx.acc, 8'h77)
      irq_level_high = 1'b1;
      op(16'h0011); `CHK(work_ctx, {8'ha5, 8'h1e, 8'h07})
      `CHK(global_high_irq_enable, 1'b1)
      op(16'h0014); `CHK(pc_value, {5'h03, 8'h12, 8'ha5})
      `CHK(stack_push, 1'b1)
      $display("return and call test done");
      op(16'heb81); op(16'hf002);
      `CHK(mem_wr, {1'b1, 12'h00a, 8'h35})
      op(16'heb02); op(16'hf123);
      `CHK(mem_wr, {1'b1, 12'h123, 8'h35})
      $display("move test done");
      close_out;
   end
endmodule // tb
bind irx_decoder irx_chk chk (.*);
